// File: pkg/flash_bus_consts.svh
`ifndef FLASH_BUS_CONSTS_SVH
`define FLASH_BUS_CONSTS_SVH

// ----------------------------------------------------------------
// Field positions, bus widths, reset values and sync read latency
// ----------------------------------------------------------------
`define STATUS_RESET_VAL 8'h80
`define WAIT_POLARITY_POS 10
`define READ_CONFIG_RESET 16'hffff
`define DATA_W 16
`define ADDR_W 24
`define BLOCK_SEL_LSB 16
`define SYNC_LATENCY_CYC 4'h2

`endif

// File: pkg/flash_bus_pkg.sv
package flash_bus_pkg;

    // ----------------------------------------------------------------
    // Bus states, Gray coded along reset -> async read -> sync read
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_ASYNC_READ = 3'b001,
        ST_SYNC_READ = 3'b011,
        ST_WRITE = 3'b010,
        ST_OUT_DISABLE = 3'b110,
        ST_STANDBY = 3'b111
    } bus_state_t;

    // Synchronised control pins, all active low except burst_clk
    typedef struct packed {
        logic reset_n;
        logic chip_sel_n;
        logic out_en_n;
        logic write_n;
        logic address_latch_n;
        logic write_prot_n;
        logic burst_clk;
    } ctrl_pins_t;

    // Captured write cycle handed to the command logic
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] data;
    } write_cycle_t;

endpackage : flash_bus_pkg

// File: hw/pin_sync.sv
`timescale 1ns/1ps
`include "flash_bus_consts.svh"

// Two-stage synchroniser for a bundle of pins
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // ----------------------------------------------------------------
    // Next values: first stage feeds only the second
    // ----------------------------------------------------------------
    always_comb begin
        meta_d = ce ? pin : meta_q;
        sync_d = ce ? meta_q : sync_q;
    end

    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync = sync_q;

endmodule : pin_sync

// File: hw/flash_bus_cycle_decoder.sv
// Overview of operation
// - Reset pin low holds automation in reset and refuses every write.
// - Leaving reset enters asynchronous array read.
// - Write address and data captured on first rising edge of write or select.
// - Guard low: unlock aimed at a locked-down block is ignored.
// - Guard high: lockdown overridden, locked-down blocks may be altered.
// - Data lines take writes, drive reads, float if select or enable inactive.
// - Wait polarity comes from bit 10 of the read configuration register.
// - Synchronous reads assert wait while data invalid, deassert when valid.
// - Asynchronous reads and writes keep wait deasserted.
// - Wait driven only while select and output enable both low.
// - Reads enabled by select low, reset high; upper address picks block.
// - Address latch strobe low keeps address latches transparent.
// - Output enable low during read drives selected data.
// - Output enable high floats data lines and wait.
// - After reset, status is 0x80 and asynchronous array read selected.
`timescale 1ns/1ps
`include "flash_bus_consts.svh"

module flash_bus_cycle_decoder #(
    parameter int DATA_W = `DATA_W,
    parameter int ADDR_W = `ADDR_W,
    parameter int BLOCK_LSB = `BLOCK_SEL_LSB
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic reset_n,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_n,
    input wire logic address_latch_n,
    input wire logic write_prot_n,
    input wire logic burst_clk,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic [DATA_W-1:0] array_data,
    input wire logic [15:0] read_config_reg,
    input wire logic sync_mode,
    input wire logic unlock_req,
    input wire logic block_locked_down,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    output logic wait_out,
    output logic wait_oe_n,
    output logic [ADDR_W-BLOCK_LSB-1:0] block_sel,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [DATA_W-1:0] wr_data,
    output logic wr_strobe,
    output logic unlock_grant,
    output logic automation_rst,
    output logic [7:0] status,
    output logic [2:0] bus_state
);

    flash_bus_pkg::ctrl_pins_t pins_raw;
    flash_bus_pkg::ctrl_pins_t pins;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] dq_s;

    // ----------------------------------------------------------------
    // Pin synchronisers: every pin crosses in from the host side
    // ----------------------------------------------------------------
    assign pins_raw = '{reset_n: reset_n, chip_sel_n: chip_sel_n, out_en_n: out_en_n,
                        write_n: write_n, address_latch_n: address_latch_n,
                        write_prot_n: write_prot_n, burst_clk: burst_clk};

    // Pins reset with reset_n low and the other strobes high; burst clock low so no false rising edge follows reset
    pin_sync #(.WIDTH(7), .RESET_VAL(7'h3e)) u_ctrl_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin(pins_raw),
        .sync(pins)
    );

    pin_sync #(.WIDTH(ADDR_W + DATA_W), .RESET_VAL('0)) u_bus_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin({addr, dq_in}),
        .sync({addr_s, dq_s})
    );

    // ----------------------------------------------------------------
    // Bus state decode
    // ----------------------------------------------------------------
    flash_bus_pkg::bus_state_t state_q, state_d;
    logic write_active;
    logic write_end;
    logic write_q, write_d;
    logic burst_clk_q, burst_clk_d;
    logic clk_rise;
    logic [3:0] lat_q, lat_d;
    logic [ADDR_W-1:0] latch_q, latch_d;
    logic [ADDR_W-1:0] eff_addr;

    // Write cycle is select and write low while reset and enable high
    assign write_active = pins.reset_n && !pins.chip_sel_n && !pins.write_n && pins.out_en_n;
    // Whichever of write or select rises first ends the cycle
    assign write_end = write_q && (pins.write_n || pins.chip_sel_n);
    assign clk_rise = pins.burst_clk && !burst_clk_q;
    // Latch is transparent while its strobe is low
    assign eff_addr = pins.address_latch_n ? latch_q : addr_s;

    // State and latch next values
    always_comb begin
        state_d = state_q;
        write_d = write_active;
        burst_clk_d = pins.burst_clk;
        latch_d = pins.address_latch_n ? latch_q : addr_s;
        lat_d = lat_q;
        if (!pins.reset_n) begin
            state_d = flash_bus_pkg::ST_RESET;
            write_d = 1'b0;
        end else if (pins.chip_sel_n) begin
            state_d = flash_bus_pkg::ST_STANDBY;
        end else if (write_active) begin
            state_d = flash_bus_pkg::ST_WRITE;
        end else if (pins.out_en_n) begin
            state_d = flash_bus_pkg::ST_OUT_DISABLE;
        end else if (sync_mode) begin
            state_d = flash_bus_pkg::ST_SYNC_READ;
        end else begin
            state_d = flash_bus_pkg::ST_ASYNC_READ;
        end
        // Latency restarts with each burst; the host may hold the strobe low all through it
        if (state_d != flash_bus_pkg::ST_SYNC_READ) begin
            lat_d = `SYNC_LATENCY_CYC;
        end else if (clk_rise && lat_q != 4'h0) begin
            lat_d = lat_q - 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= flash_bus_pkg::ST_RESET;
            write_q <= 1'b0;
            burst_clk_q <= 1'b0;
            lat_q <= `SYNC_LATENCY_CYC;
            latch_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
            write_q <= write_d;
            burst_clk_q <= burst_clk_d;
            lat_q <= lat_d;
            latch_q <= latch_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all registered
    // ----------------------------------------------------------------
    flash_bus_pkg::write_cycle_t wcap_q, wcap_d;
    logic [DATA_W-1:0] dq_out_q, dq_out_d;
    logic dq_oe_n_q, dq_oe_n_d;
    logic wait_q, wait_d;
    logic wait_oe_n_q, wait_oe_n_d;
    logic wr_strobe_q, wr_strobe_d;
    logic unlock_q, unlock_d;
    logic [ADDR_W-BLOCK_LSB-1:0] block_q, block_d;
    logic [7:0] status_q, status_d;
    logic drive;
    logic wait_level;

    // Drive only when reset high, select low, enable low and no write in progress
    assign drive = pins.reset_n && !pins.chip_sel_n && !pins.out_en_n && pins.write_n;
    // Asserted level follows the polarity bit; deasserted is its inverse
    assign wait_level = (state_d == flash_bus_pkg::ST_SYNC_READ) && (lat_d != 4'h0);

    // Next values of the output registers
    always_comb begin
        wcap_d = wcap_q;
        wr_strobe_d = 1'b0;
        unlock_d = 1'b0;
        block_d = eff_addr[ADDR_W-1:BLOCK_LSB];
        status_d = status_q;
        dq_out_d = drive ? array_data : '0;
        dq_oe_n_d = !drive;
        wait_oe_n_d = !drive;
        wait_d = wait_level ~^ read_config_reg[`WAIT_POLARITY_POS];
        if (!pins.reset_n) begin
            status_d = `STATUS_RESET_VAL;
        end else if (write_end) begin
            wcap_d = '{addr: eff_addr, data: dq_s};
            wr_strobe_d = 1'b1;
        end
        // Lockdown guard: with guard low a locked-down block stays locked
        if (pins.reset_n && unlock_req) begin
            unlock_d = pins.write_prot_n || !block_locked_down;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wcap_q <= '0;
            wr_strobe_q <= 1'b0;
            unlock_q <= 1'b0;
            block_q <= '0;
            status_q <= `STATUS_RESET_VAL;
            dq_out_q <= '0;
            dq_oe_n_q <= 1'b1;
            wait_q <= 1'b0;
            wait_oe_n_q <= 1'b1;
        end else if (ce) begin
            wcap_q <= wcap_d;
            wr_strobe_q <= wr_strobe_d;
            unlock_q <= unlock_d;
            block_q <= block_d;
            status_q <= status_d;
            dq_out_q <= dq_out_d;
            dq_oe_n_q <= dq_oe_n_d;
            wait_q <= wait_d;
            wait_oe_n_q <= wait_oe_n_d;
        end
    end

    // Automation reset tracks the pin; registered for a clean output
    logic auto_rst_q, auto_rst_d;
    always_comb begin
        auto_rst_d = !pins.reset_n;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            auto_rst_q <= 1'b1;
        end else if (ce) begin
            auto_rst_q <= auto_rst_d;
        end
    end

    assign dq_out = dq_out_q;
    assign dq_oe_n = dq_oe_n_q;
    assign wait_out = wait_q;
    assign wait_oe_n = wait_oe_n_q;
    assign block_sel = block_q;
    assign wr_addr = wcap_q.addr;
    assign wr_data = wcap_q.data;
    assign wr_strobe = wr_strobe_q;
    assign unlock_grant = unlock_q;
    assign automation_rst = auto_rst_q;
    assign status = status_q;
    assign bus_state = state_q;

endmodule : flash_bus_cycle_decoder

// File: test/flash_bus_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// Pin decode checker
// ----------------------------------------
module flash_bus_monitor #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 24,
    parameter int BLOCK_LSB = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_n,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_n,
    input wire logic address_latch_n,
    input wire logic write_prot_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [15:0] read_config_reg,
    input wire logic sync_mode,
    input wire logic unlock_req,
    input wire logic block_locked_down,
    input wire logic dq_oe_n,
    input wire logic wait_out,
    input wire logic wait_oe_n,
    input wire logic [ADDR_W-BLOCK_LSB-1:0] block_sel,
    input wire logic wr_strobe,
    input wire logic unlock_grant,
    input wire logic automation_rst,
    input wire logic [7:0] status
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Pins cross two sync stages and a register, so five steady cycles are enough to settle
    property p_rst; !reset_n [*5] |-> dq_oe_n && wait_oe_n && automation_rst && status == 8'h80; endproperty
    a_rst: assert property (p_rst) else $error("outputs live in pin reset");
    property p_no_wr; wr_strobe |-> !automation_rst && !$past(automation_rst); endproperty
    a_no_wr: assert property (p_no_wr) else $error("write taken in reset");
    property p_standby; (chip_sel_n && reset_n) [*5] |-> dq_oe_n && wait_oe_n; endproperty
    a_standby: assert property (p_standby) else $error("driving while deselected");
    property p_out_dis; out_en_n [*5] |-> dq_oe_n && wait_oe_n; endproperty
    a_out_dis: assert property (p_out_dis) else $error("driving with output off");
    property p_wait_drv; !wait_oe_n |-> !$past(chip_sel_n, 3) && !$past(out_en_n, 3); endproperty
    a_wait_drv: assert property (p_wait_drv) else $error("wait driven without select");
    property p_async; (reset_n && !chip_sel_n && !out_en_n && !sync_mode && $stable(read_config_reg)) [*5]
        |-> wait_out != read_config_reg[10]; endproperty
    a_async: assert property (p_async) else $error("wait asserted in async read");
    property p_wr_float; (!write_n && out_en_n) [*5] |-> dq_oe_n && wait_oe_n; endproperty
    a_wr_float: assert property (p_wr_float) else $error("driving during write");
    // Burst clock keeps running in every burst, so wait must clear within a dozen cycles
    property p_sync; $fell(wait_oe_n) && sync_mode |-> wait_out == read_config_reg[10]
        ##[1:12] wait_out != read_config_reg[10]; endproperty
    a_sync: assert property (p_sync) else $error("burst wait wrong");
    property p_lock; !write_prot_n [*4] ##0 (unlock_req && block_locked_down) |=> !unlock_grant; endproperty
    a_lock: assert property (p_lock) else $error("unlock of locked block");
    property p_latch; (reset_n && !address_latch_n && $stable(addr)) [*5]
        |-> block_sel == addr[ADDR_W-1:BLOCK_LSB]; endproperty
    a_latch: assert property (p_latch) else $error("block select stale");
    c_wr: cover property (wr_strobe);
    c_grant: cover property (unlock_grant);
    c_sync: cover property ($fell(wait_oe_n) && sync_mode);
endmodule : flash_bus_monitor

bind flash_bus_cycle_decoder flash_bus_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .BLOCK_LSB(BLOCK_LSB))
    flash_bus_monitor_inst (.clk, .rst, .reset_n, .chip_sel_n, .out_en_n, .write_n, .address_latch_n,
    .write_prot_n, .addr, .read_config_reg, .sync_mode, .unlock_req, .block_locked_down, .dq_oe_n,
    .wait_out, .wait_oe_n, .block_sel, .wr_strobe, .unlock_grant, .automation_rst, .status);

// File: test/flash_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host master on the flash pins
// ----------------------------------------
// op: 0 standby, 1 async read, 2 burst read, 3 write, 4 output off, 5 reset, 6 write in reset
module flash_host_model (
    input wire logic clk,
    input wire logic [2:0] op,
    input wire logic [23:0] a,
    input wire logic [15:0] wd,
    input wire logic lat,
    input wire logic wp,
    output logic reset_n,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_n,
    output logic address_latch_n,
    output logic write_prot_n,
    output logic burst_clk,
    output logic [23:0] addr,
    output logic [15:0] dq_in
);
    // Idle pins at time zero
    initial begin
        {reset_n, chip_sel_n, out_en_n, write_n, address_latch_n, write_prot_n, burst_clk} = 7'h7a;
        addr = 24'h00_0000;
        dq_in = 16'h0000;
    end
    // Levels change just after the edge; reset_n, chip_sel_n, out_en_n and write_n hold for the whole op
    always @(posedge clk) begin
        reset_n <= op < 3'h5;
        chip_sel_n <= op == 3'h0;
        out_en_n <= op > 3'h2;
        write_n <= op != 3'h3 && op != 3'h6;
        burst_clk <= op == 3'h2 && !burst_clk; // Still outside bursts
        address_latch_n <= lat;
        write_prot_n <= wp;
        addr <= a;
        dq_in <= write_n ? ~dq_in : wd; // Released lines toggle, so stale data cannot pass
    end
endmodule : flash_host_model

// File: test/flash_bus_cycle_decoder_bench.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench for the flash pin decoder
// ----------------------------------------
module flash_bus_cycle_decoder_bench;
    logic clk, reset_n, chip_sel_n, out_en_n, write_n, address_latch_n, write_prot_n, burst_clk;
    logic rst = 1'b1, ce = 1'b1, sync_mode = 1'b0, unlock_req = 1'b0, block_locked_down = 1'b0, lat = 1'b0;
    logic wp = 1'b1, dq_oe_n, wait_out, wait_oe_n, wr_strobe, unlock_grant, automation_rst;
    logic [2:0] op = 3'h0, bus_state;
    logic [7:0] block_sel, status;
    logic [15:0] wd = 16'hc3a5, array_data = 16'h9e61, read_config_reg = 16'h0000, dq_in, dq_out, wr_data;
    logic [23:0] a = 24'h12_3456, addr, wr_addr;
    int fails, cmp_count, cyc, strobes;

    flash_host_model flash_host_model_inst (.clk, .op, .a, .wd, .lat, .wp, .reset_n, .chip_sel_n,
        .out_en_n, .write_n, .address_latch_n, .write_prot_n, .burst_clk, .addr, .dq_in);
    flash_bus_cycle_decoder flash_bus_cycle_decoder_inst (.clk, .rst, .ce, .reset_n, .chip_sel_n,
        .out_en_n, .write_n, .address_latch_n, .write_prot_n, .burst_clk, .addr, .dq_in, .array_data,
        .read_config_reg, .sync_mode, .unlock_req, .block_locked_down, .dq_out, .dq_oe_n, .wait_out,
        .wait_oe_n, .block_sel, .wr_addr, .wr_data, .wr_strobe, .unlock_grant, .automation_rst, .status,
        .bus_state);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_sim;
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // Hang guard well above the 150 or so cycles the run needs; also counts write strobes
    always @(posedge clk) begin
        cyc++;
        if (wr_strobe === 1'b1) strobes++;
        if (cyc == 2000) begin
            fails++;
            end_sim();
        end
    end

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Apply an op at an edge, then look just after the n-th following edge
    task automatic go(input logic [2:0] o, input int n);
        @(posedge clk);
        op <= o;
        repeat (n) @(posedge clk);
        #1;
    endtask : go

    task automatic await_sig(ref logic s, input logic v);
        for (int i = 0; i < 20 && s !== v; i++) begin
            @(posedge clk);
            #1;
        end
    endtask : await_sig

    task automatic t_reset;
        repeat (5) @(posedge clk);
        #1;
        chk(status, 8'h80);
        chk(bus_state, 3'h0);
        @(posedge clk);
        rst <= 1'b0;
        go(3'h6, 6);
        chk(dq_oe_n, 1'b1);
        chk(automation_rst, 1'b1);
        go(3'h5, 6);
        go(3'h0, 6);
        chk(24'(strobes), 24'h00_0000);
        chk(dq_oe_n, 1'b1);
        chk(bus_state, 3'h7);
    endtask : t_reset

    task automatic t_async;
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            read_config_reg <= p[0] ? 16'h0400 : 16'h0000;
            go(3'h1, 6);
            chk(dq_oe_n, 1'b0);
            chk(dq_out, array_data);
            chk(wait_out, !p[0]);
            chk(bus_state, 3'h1);
            chk(block_sel, a[23:16]);
            go(3'h4, 6);
            chk(wait_oe_n, 1'b1);
            chk(bus_state, 3'h6);
        end
    endtask : t_async

    task automatic t_latch;
        @(posedge clk);
        lat <= 1'b1;
        repeat (4) @(posedge clk);
        a <= 24'h3c_1234;
        go(3'h1, 6);
        chk(block_sel, 8'h12);
        @(posedge clk);
        lat <= 1'b0;
        go(3'h1, 6);
        chk(block_sel, 8'h3c);
    endtask : t_latch

    task automatic t_sync;
        go(3'h4, 6);
        chk(wait_oe_n, 1'b1);
        @(posedge clk);
        sync_mode <= 1'b1;
        lat <= 1'b0; // Strobe held low through the burst
        go(3'h2, 0);
        await_sig(wait_oe_n, 1'b0);
        chk(wait_out, 1'b1);
        await_sig(wait_out, 1'b0);
        chk(wait_out, 1'b0);
        chk(bus_state, 3'h3);
        go(3'h0, 6);
        chk(wait_oe_n, 1'b1);
    endtask : t_sync

    task automatic t_write;
        @(posedge clk);
        sync_mode <= 1'b0;
        lat <= 1'b0;
        a <= 24'h7e_0042;
        go(3'h3, 6);
        chk(dq_oe_n, 1'b1);
        chk(wait_oe_n, 1'b1);
        chk(bus_state, 3'h2);
        go(3'h4, 0);
        await_sig(wr_strobe, 1'b1);
        chk(wr_strobe, 1'b1);
        chk(wr_addr, 24'h7e_0042);
        chk(wr_data, 16'hc3a5);
    endtask : t_write

    task automatic t_unlock;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            wp <= i[1];
            block_locked_down <= i[0];
            repeat (5) @(posedge clk);
            unlock_req <= 1'b1;
            @(posedge clk);
            unlock_req <= 1'b0;
            #1;
            chk(unlock_grant, i[1] || !i[0]);
        end
    endtask : t_unlock

    initial begin
        t_reset();
        t_async();
        t_latch();
        t_sync();
        t_write();
        t_unlock();
        end_sim();
    end
endmodule : flash_bus_cycle_decoder_bench
